//--- src/cod_decode_core.sv
// cod_decode_core: decode and timed execution of one instruction slice
// assumes: a neighbour fetches the opcode and its second byte and pulses start;
// memory answers a read with data on mem_rdata in the cycle after the request
//
// Operation
// RL1: copy registers into L or A
// RL2: register or into A, four cycles
// RL3: or memory at HL, seven cycles
// RL4: or immediate byte, two bytes, seven
// RL5: jump via HL pair in five cycles
// RL6: pull BC, DE, HL in ten cycles
// RL7: pull A and flags, restore flags
// RL8: push BC, DE, HL in eleven cycles
// RL9: push A and flags, eleven cycles
// RL10: rotate left through carry, carry only
// RL11: rotate right through carry, carry only
// RL12: rotate left circular, bit seven to carry
// RL13: conditional return five or eleven, plain ten
// RL14: full-flag instructions update all flags
// RL15: immediate loads seven, memory store ten
// RL16: idle four cycles, output ten cycles
`timescale 1ns/1ns
`include "cod_defines.svh"

module cod_decode_core
    import cod_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // instruction from fetch
    input  wire logic       start,
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] operand,
    // memory read data
    input  wire logic [7:0] mem_rdata,
    // status
    output logic            busy,
    output logic            done,
    output logic            illegal,
    // processor bus
    output cod_mem_t        mem,
    output cod_io_t         io,
    // architectural state
    output cod_regs_t       regs
);

    cod_state_t state;
    cod_dec_t   dec;
    cod_kind_t  kind_q;
    cod_regs_t  next_regs;
    logic [7:0] op_q;
    logic [7:0] imm_q;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic [4:0] cycles_q;
    logic [15:0] len_q;
    logic       taken_q;
    logic [4:0] step;
    logic       accept;
    logic       commit;
    logic [7:0] or_src;
    logic [7:0] or_result;
    logic [7:0] or_flags;

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] reg_by_code(input cod_regs_t r, input logic [2:0] code);
        case (code)
            3'h0:    reg_by_code = r.b;
            3'h1:    reg_by_code = r.c;
            3'h2:    reg_by_code = r.d;
            3'h3:    reg_by_code = r.e;
            3'h4:    reg_by_code = r.h;
            3'h5:    reg_by_code = r.l;
            3'h7:    reg_by_code = r.a;
            default: reg_by_code = 8'h00;
        endcase
    endfunction

    function automatic cod_regs_t set_reg(input cod_regs_t r, input logic [2:0] code,
                                          input logic [7:0] v);
        set_reg = r;
        case (code)
            3'h0:    set_reg.b = v;
            3'h1:    set_reg.c = v;
            3'h2:    set_reg.d = v;
            3'h3:    set_reg.e = v;
            3'h4:    set_reg.h = v;
            3'h5:    set_reg.l = v;
            3'h7:    set_reg.a = v;
            default: set_reg = r;
        endcase
    endfunction

    // pair code: 0 bc, 1 de, 2 hl, 3 a with flags
    function automatic logic [15:0] pair_word(input cod_regs_t r, input logic [1:0] p);
        case (p)
            2'h0:    pair_word = {r.b, r.c};
            2'h1:    pair_word = {r.d, r.e};
            2'h2:    pair_word = {r.h, r.l};
            default: pair_word = {r.a, r.f};
        endcase
    endfunction

    function automatic logic cond_true(input logic [7:0] f, input logic [2:0] cc);
        case (cc)
            3'h0:    cond_true = ~f[`COD_F_Z_POS];
            3'h1:    cond_true = f[`COD_F_Z_POS];
            3'h2:    cond_true = ~f[`COD_F_CY_POS];
            3'h3:    cond_true = f[`COD_F_CY_POS];
            3'h4:    cond_true = ~f[`COD_F_P_POS];
            3'h5:    cond_true = f[`COD_F_P_POS];
            3'h6:    cond_true = ~f[`COD_F_S_POS];
            default: cond_true = f[`COD_F_S_POS];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode of the incoming opcode; flags are stable while idle

    always_comb
    begin
        dec = '{kind: K_BAD, cycles: `COD_CYC_BAD, len: `COD_LEN_ONE, taken: 1'b0};
        casez (opcode)
            8'b0110_1???, 8'b0111_1???:
            begin
                if (opcode[2:0] != `COD_R_MEM)
                    dec = '{K_COPY, `COD_CYC_COPY, `COD_LEN_ONE, 1'b0}; // RL1
            end
            8'b1011_0???:
            begin
                if (opcode[2:0] == `COD_R_MEM)
                    dec = '{K_OR, `COD_CYC_OR_M, `COD_LEN_ONE, 1'b0}; // RL3
                else
                    dec = '{K_OR, `COD_CYC_OR_R, `COD_LEN_ONE, 1'b0}; // RL2
            end
            `COD_OP_ORI: dec = '{K_OR, `COD_CYC_ORI, `COD_LEN_TWO, 1'b0}; // RL4
            `COD_OP_JHL: dec = '{K_JHL, `COD_CYC_JHL, `COD_LEN_ONE, 1'b0}; // RL5
            8'b11??_0001: dec = '{K_POP, `COD_CYC_POP, `COD_LEN_ONE, 1'b0}; // RL6 RL7
            8'b11??_0101: dec = '{K_PUSH, `COD_CYC_PUSH, `COD_LEN_ONE, 1'b0}; // RL8 RL9
            `COD_OP_RLC, `COD_OP_RAL, `COD_OP_RAR:
                dec = '{K_ROT, `COD_CYC_ROT, `COD_LEN_ONE, 1'b0};
            `COD_OP_RET: dec = '{K_RET, `COD_CYC_RET, `COD_LEN_ONE, 1'b1}; // RL13
            8'hd8, 8'hd0, 8'hc0, 8'hf8, 8'hf0:
            begin
                if (cond_true(regs.f, opcode[5:3]))
                    dec = '{K_RET, `COD_CYC_RET_YES, `COD_LEN_ONE, 1'b1}; // RL13
                else
                    dec = '{K_RET, `COD_CYC_RET_NO, `COD_LEN_ONE, 1'b0}; // RL13
            end
            8'b00??_?110:
            begin
                if (opcode == `COD_OP_STI)
                    dec = '{K_STI, `COD_CYC_STI, `COD_LEN_TWO, 1'b0}; // RL15
                else
                    dec = '{K_LDI, `COD_CYC_LDI, `COD_LEN_TWO, 1'b0}; // RL15
            end
            `COD_OP_IDLE: dec = '{K_IDLE, `COD_CYC_IDLE, `COD_LEN_ONE, 1'b0}; // RL16
            `COD_OP_OUT:  dec = '{K_OUT, `COD_CYC_OUT, `COD_LEN_TWO, 1'b0}; // RL16
            default:      dec = '{K_BAD, `COD_CYC_BAD, `COD_LEN_ONE, 1'b0};
        endcase
    end

    assign accept = (state == ST_IDLE) && start;
    assign commit = (state == ST_EXEC) && (step == cycles_q - 5'h01);

    ////////////////////////////////////////////////////////////////////////////
    // sequencing: step counts edges since the opcode was taken

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            step  <= 5'h00;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            done <= commit;
            case (state)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        state <= ST_EXEC;
                        step  <= 5'h01;
                        busy  <= 1'b1;
                    end
                end
                ST_EXEC:
                begin
                    if (commit)
                    begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                    end
                    else
                        step <= step + 5'h01;
                end
                default:
                begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            kind_q   <= K_IDLE;
            op_q     <= 8'h00;
            imm_q    <= 8'h00;
            cycles_q <= `COD_CYC_IDLE;
            len_q    <= `COD_LEN_ONE;
            taken_q  <= 1'b0;
            illegal  <= 1'b0;
        end
        else if (accept)
        begin
            kind_q   <= dec.kind;
            op_q     <= opcode;
            imm_q    <= operand;
            cycles_q <= dec.cycles;
            len_q    <= dec.len;
            taken_q  <= dec.taken;
            illegal  <= (dec.kind == K_BAD);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus traffic: first access in cycle 1, second in cycle 2

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            mem <= '0;
        else
        begin
            mem.rd <= 1'b0;
            mem.wr <= 1'b0;
            if (accept)
            begin
                if (dec.kind == K_OR && opcode[2:0] == `COD_R_MEM && opcode != `COD_OP_ORI)
                begin
                    mem.rd   <= 1'b1; // RL3
                    mem.addr <= {regs.h, regs.l};
                end
                else if (dec.kind == K_POP || (dec.kind == K_RET && dec.taken))
                begin
                    mem.rd   <= 1'b1; // RL6 RL7 RL13
                    mem.addr <= regs.sp;
                end
                else if (dec.kind == K_PUSH)
                begin
                    mem.wr    <= 1'b1; // RL8 RL9
                    mem.addr  <= regs.sp - 16'h0001;
                    mem.wdata <= 8'(pair_word(regs, opcode[5:4]) >> 8);
                end
                else if (dec.kind == K_STI)
                begin
                    mem.wr    <= 1'b1; // RL15
                    mem.addr  <= {regs.h, regs.l};
                    mem.wdata <= operand;
                end
            end
            else if (state == ST_EXEC && step == 5'h01)
            begin
                if (kind_q == K_POP || (kind_q == K_RET && taken_q))
                begin
                    mem.rd   <= 1'b1;
                    mem.addr <= regs.sp + 16'h0001;
                end
                else if (kind_q == K_PUSH)
                begin
                    mem.wr    <= 1'b1;
                    mem.addr  <= regs.sp - 16'h0002;
                    mem.wdata <= 8'(pair_word(regs, op_q[5:4]));
                end
            end
        end
    end

    // read data follow their requests by one cycle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            lo_q <= 8'h00;
            hi_q <= 8'h00;
        end
        else if (state == ST_EXEC)
        begin
            if (step == 5'h02)
                lo_q <= mem_rdata;
            if (step == 5'h03)
                hi_q <= mem_rdata;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            io <= '0;
        else
        begin
            io.wr <= 1'b0;
            if (accept && dec.kind == K_OUT)
            begin
                io.wr   <= 1'b1; // RL16
                io.port <= operand;
                io.data <= regs.a;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // results, all written back on the last cycle

    always_comb
    begin
        if (op_q == `COD_OP_ORI)
            or_src = imm_q; // RL4
        else if (op_q[2:0] == `COD_R_MEM)
            or_src = lo_q; // RL3
        else
            or_src = reg_by_code(regs, op_q[2:0]); // RL2
        or_result = regs.a | or_src;
    end

    cod_logic_flags u_flags
    (
        .result (or_result),
        .flags  (or_flags)
    );

    always_comb
    begin
        next_regs    = regs;
        next_regs.pc = regs.pc + len_q;
        case (kind_q)
            K_COPY: next_regs = set_reg(regs, op_q[5:3], reg_by_code(regs, op_q[2:0])); // RL1
            K_OR:
            begin
                next_regs.a = or_result; // RL2
                next_regs.f = or_flags; // RL14
            end
            K_JHL: next_regs.pc = {regs.h, regs.l}; // RL5
            K_POP:
            begin
                if (op_q[5:4] == `COD_PAIR_AF)
                begin
                    next_regs.a = hi_q; // RL7
                    next_regs.f = (lo_q & `COD_F_FIXED_MASK) | `COD_F_FIXED_ONE; // RL7
                end
                else
                    next_regs = set_reg(set_reg(next_regs, {op_q[5:4], 1'b0}, hi_q),
                                        {op_q[5:4], 1'b1}, lo_q); // RL6
                next_regs.sp = regs.sp + 16'h0002;
            end
            K_PUSH: next_regs.sp = regs.sp - 16'h0002; // RL8 RL9
            K_ROT:
            begin
                // only the carry bit of the flag byte moves
                next_regs.f[`COD_F_CY_POS] = (op_q == `COD_OP_RAR) ? regs.a[0] : regs.a[7];
                if (op_q == `COD_OP_RLC)
                    next_regs.a = {regs.a[6:0], regs.a[7]}; // RL12
                else if (op_q == `COD_OP_RAL)
                    next_regs.a = {regs.a[6:0], regs.f[`COD_F_CY_POS]}; // RL10
                else
                    next_regs.a = {regs.f[`COD_F_CY_POS], regs.a[7:1]}; // RL11
            end
            K_RET:
            begin
                if (taken_q)
                begin
                    next_regs.pc = {hi_q, lo_q}; // RL13
                    next_regs.sp = regs.sp + 16'h0002;
                end
            end
            K_LDI: next_regs = set_reg(next_regs, op_q[5:3], imm_q); // RL15
            default: next_regs = next_regs;
        endcase
        if (kind_q == K_COPY || kind_q == K_LDI)
            next_regs.pc = regs.pc + len_q;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            regs   <= '0;
            regs.f <= `COD_FLAGS_RESET;
        end
        else if (commit)
            regs <= next_regs;
    end

endmodule

//--- src/cod_defines.svh
// cod_defines.svh: opcodes, cycle counts, lengths and flag layout
// assumes: included by bare name from the two design modules, not from the package
`ifndef COD_DEFINES_SVH
`define COD_DEFINES_SVH

// flag byte bit positions
`define COD_F_CY        3
`define COD_F_CY_POS    0
`define COD_F_ONE_POS   1
`define COD_F_P_POS     2
`define COD_F_AC_POS    4
`define COD_F_Z_POS     6
`define COD_F_S_POS     7
`define COD_F_FIXED_MASK 8'hd5
`define COD_F_FIXED_ONE  8'h02
`define COD_FLAGS_RESET  8'h02

// single opcodes
`define COD_OP_IDLE     8'h00
`define COD_OP_RLC      8'h07
`define COD_OP_RAL      8'h17
`define COD_OP_RAR      8'h1f
`define COD_OP_STI      8'h36
`define COD_OP_ORI      8'hf6
`define COD_OP_JHL      8'he9
`define COD_OP_RET      8'hc9
`define COD_OP_OUT      8'hd3

// register codes and pair codes
`define COD_R_L         3'h5
`define COD_R_MEM       3'h6
`define COD_R_A         3'h7
`define COD_PAIR_AF     2'h3

// clock cycles per instruction
`define COD_CYC_COPY    5'h05
`define COD_CYC_OR_R    5'h04
`define COD_CYC_OR_M    5'h07
`define COD_CYC_ORI     5'h07
`define COD_CYC_JHL     5'h05
`define COD_CYC_POP     5'h0a
`define COD_CYC_PUSH    5'h0b
`define COD_CYC_ROT     5'h04
`define COD_CYC_RET_NO  5'h05
`define COD_CYC_RET_YES 5'h0b
`define COD_CYC_RET     5'h0a
`define COD_CYC_LDI     5'h07
`define COD_CYC_STI     5'h0a
`define COD_CYC_IDLE    5'h04
`define COD_CYC_OUT     5'h0a
`define COD_CYC_BAD     5'h04

// instruction lengths in bytes
`define COD_LEN_ONE     16'h0001
`define COD_LEN_TWO     16'h0002

`endif

//--- src/cod_pkg.sv
// cod_pkg: types shared by the decode core and its flag helper
// assumes: cod_defines.svh sits on the include path
package cod_pkg;

    typedef enum logic [3:0]
    {
        K_BAD  = 4'h0,
        K_COPY = 4'h1,
        K_OR   = 4'h2,
        K_JHL  = 4'h3,
        K_POP  = 4'h4,
        K_PUSH = 4'h5,
        K_ROT  = 4'h6,
        K_RET  = 4'h7,
        K_LDI  = 4'h8,
        K_STI  = 4'h9,
        K_IDLE = 4'ha,
        K_OUT  = 4'hb
    } cod_kind_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } cod_state_t;

    typedef struct packed
    {
        logic [7:0]  a;
        logic [7:0]  f;
        logic [7:0]  b;
        logic [7:0]  c;
        logic [7:0]  d;
        logic [7:0]  e;
        logic [7:0]  h;
        logic [7:0]  l;
        logic [15:0] sp;
        logic [15:0] pc;
    } cod_regs_t;

    typedef struct packed
    {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cod_mem_t;

    typedef struct packed
    {
        logic       wr;
        logic [7:0] port;
        logic [7:0] data;
    } cod_io_t;

    typedef struct packed
    {
        cod_kind_t   kind;
        logic [4:0]  cycles;
        logic [15:0] len;
        logic        taken;
    } cod_dec_t;

endpackage

//--- src/cod_logic_flags.sv
// cod_logic_flags: flag byte for a logical result
// assumes: purely combinational, fed from the core's or result
`timescale 1ns/1ns
`include "cod_defines.svh"

module cod_logic_flags
    import cod_pkg::*;
(
    // result in, flags out
    input  wire logic [7:0] result,
    output logic      [7:0] flags
);

    // or clears carry and aux carry; sign, zero, parity follow the result
    always_comb
    begin
        flags                       = `COD_F_FIXED_ONE; // RL14
        flags[`COD_F_S_POS]         = result[7]; // RL14
        flags[`COD_F_Z_POS]         = (result == 8'h00); // RL14
        flags[`COD_F_P_POS]         = ~^result; // RL14
    end

endmodule

//--- testbench/cod_mem_model.sv
// cod_mem_model: byte memory on the core's processor bus
// assumes: reads answered in the cycle after the request, no wait states
`timescale 1ns/1ns

module cod_mem_model
    import cod_pkg::*;
(
    // clock and bus
    input  wire logic     clock,
    input  wire cod_mem_t mem,
    // read data back to the core
    output logic [7:0]    rdata
);
    // only the low address byte decodes, so the stack and hl pointer alias
    logic [7:0] store [256];

    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            store[i] = 8'(i) ^ 8'ha5;
        end
        rdata = 8'h00;
    end

    // no read pending: flip the bus so a late sample cannot match by luck
    always @(posedge clock)
    begin
        if (mem.wr)
        begin
            store[mem.addr[7:0]] <= mem.wdata;
        end
        rdata <= mem.rd ? store[mem.addr[7:0]] : ~rdata;
    end
endmodule

//--- testbench/cod_decode_core_sva.sv
// cod_decode_core_sva: timing and result checks at the core's ports
// assumes: bound to cod_decode_core, one clock, async active-low reset
`timescale 1ns/1ns

module cod_decode_core_sva
    import cod_pkg::*;
(
    // clock and reset
    input wire logic       clock,
    input wire logic       rstn,
    // instruction and status
    input wire logic       start,
    input wire logic [7:0] opcode,
    input wire logic       busy,
    input wire logic       done,
    // bus and state
    input wire cod_mem_t   mem,
    input wire cod_regs_t  regs
);
    logic       take;
    logic [7:0] op_l;
    logic [4:0] cnt;
    cod_regs_t  r_l;

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    assign take = start && !busy;

    // snapshot at accept so each result is tied to the state it came from
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            op_l <= 8'h00;
            r_l  <= '0;
        end
        else if (take)
        begin
            op_l <= opcode;
            r_l  <= regs;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cnt <= 5'h00;
        else if (take)
            cnt <= 5'h01;
        else if (done)
            cnt <= 5'h00;
        else if (cnt != 5'h00)
            cnt <= cnt + 5'h01;
    end

    function automatic logic [7:0] src(cod_regs_t r, logic [2:0] s);
        logic [63:0] v;
        v = {r.a, 8'h00, r.l, r.h, r.e, r.d, r.c, r.b};
        return v[8*s +: 8];
    endfunction

    function automatic logic taken(logic [7:0] op, logic [7:0] f);
        logic [3:0] sel;
        sel = {f[7], f[2], f[0], f[6]};
        return sel[op[5:4]] == op[3];
    endfunction

    ////////////////////////////////////////
    a_copy_result: assert property (
        done && op_l[7:5] == 3'h3 && op_l[3] && op_l[2:0] != 3'h6
        |-> cnt == 5'h05 && (op_l[4] ? regs.a : regs.l) == src(r_l, op_l[2:0]))
        else $error("copy wrong");
    a_or_register: assert property (
        done && op_l[7:3] == 5'h16 && op_l[2:0] != 3'h6
        |-> cnt == 5'h04 && regs.a == (r_l.a | src(r_l, op_l[2:0])))
        else $error("register or wrong");
    a_or_long: assert property (
        done && (op_l == 8'hb6 || op_l == 8'hf6)
        |-> cnt == 5'h07 && regs.pc == r_l.pc + (op_l[6] ? 16'h0002 : 16'h0001))
        else $error("memory or immediate or wrong");
    a_or_flags: assert property (
        done && (op_l[7:3] == 5'h16 || op_l == 8'hf6)
        |-> regs.f == {regs.a[7], regs.a == 8'h00, 3'b000, ~^regs.a, 2'b10})
        else $error("or flags wrong");
    a_jump_hl: assert property (
        done && op_l == 8'he9 |-> cnt == 5'h05 && regs.pc == {r_l.h, r_l.l})
        else $error("jump via hl wrong");
    a_pull_timing: assert property (
        done && op_l[7:6] == 2'b11 && op_l[3:0] == 4'h1
        |-> cnt == 5'h0a && regs.sp == r_l.sp + 16'h0002)
        else $error("pull wrong");
    a_push_words: assert property (
        take && opcode[7:6] == 2'b11 && opcode[3:0] == 4'h5
        |-> ##1 mem.wr && mem.addr == r_l.sp - 16'h0001
        ##1 mem.wr && mem.addr == r_l.sp - 16'h0002 ##9 done)
        else $error("push wrong");
    a_rotate_carry: assert property (
        done && (op_l == 8'h07 || op_l == 8'h17 || op_l == 8'h1f)
        |-> cnt == 5'h04 && regs.f[7:1] == r_l.f[7:1] && {regs.f[0], regs.a}
        == (op_l[3] ? {r_l.a[0], r_l.f[0], r_l.a[7:1]}
        : {r_l.a, op_l[4] ? r_l.f[0] : r_l.a[7]}))
        else $error("rotate wrong");
    a_return_timing: assert property (
        done && op_l inside {8'hc0, 8'hd0, 8'hd8, 8'hf0, 8'hf8, 8'hc9}
        |-> cnt == (op_l == 8'hc9 ? 5'h0a : taken(op_l, r_l.f) ? 5'h0b : 5'h05))
        else $error("return timing wrong");

    c_push_flags: cover property (done && op_l == 8'hf5);
    c_return_taken: cover property (done && op_l == 8'hd8);
    c_jump: cover property (take && opcode == 8'he9);
endmodule

bind cod_decode_core cod_decode_core_sva i_cod_decode_core_sva
(
    .clock  (clock),
    .rstn   (rstn),
    .start  (start),
    .opcode (opcode),
    .busy   (busy),
    .done   (done),
    .mem    (mem),
    .regs   (regs)
);

//--- testbench/cod_decode_core_tb.sv
// cod_decode_core_tb: runs each instruction kind of the slice, timed
// assumes: cod_mem_model holds addr ^ a5 at start; core state zero at reset except flags 02
`timescale 1ns/1ns

module cod_decode_core_tb
    import cod_pkg::*;
;
    logic       clock;
    logic       rstn;
    logic       start;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] mem_rdata;
    logic       busy;
    logic       done;
    logic       illegal;
    cod_mem_t   mem;
    cod_io_t    io;
    cod_regs_t  regs;
    logic [7:0] io_port;
    logic [7:0] io_data;
    int         mismatches;
    int         total_checks;
    int         ticks;

    cod_decode_core i_cod_decode_core
    (
        .clock     (clock),
        .rstn      (rstn),
        .start     (start),
        .opcode    (opcode),
        .operand   (operand),
        .mem_rdata (mem_rdata),
        .busy      (busy),
        .done      (done),
        .illegal   (illegal),
        .mem       (mem),
        .io        (io),
        .regs      (regs)
    );

    cod_mem_model i_cod_mem_model
    (
        .clock (clock),
        .mem   (mem),
        .rdata (mem_rdata)
    );

    initial clock = 1'b0;
    always #2 clock = ~clock;

    // the output pulse lasts one cycle, so hold what it carried
    always @(posedge clock)
    begin
        if (io.wr)
        begin
            io_port <= io.port;
            io_data <= io.data;
        end
        ticks <= ticks + 1;
        if (ticks == 3000)
        begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end

    ////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // issue one instruction and compare cycles from accept to done
    task automatic exec(input logic [7:0] op, input logic [7:0] arg, input logic [4:0] cyc);
        int n;
        @(posedge clock);
        start   <= 1'b1;
        opcode  <= op;
        operand <= arg;
        @(posedge clock);
        start <= 1'b0;
        n = 1;
        #1;
        while (done !== 1'b1 && n < 40)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check(16'(n), 16'(cyc));
    endtask

    ////////////////////////////////////////
    task automatic t_or_immediate();
        exec(8'hf6, 8'h81, 5'h07);
        check({regs.a, regs.f}, 16'h8186);
        check(regs.pc, 16'h0002);
    endtask

    task automatic t_pull_pairs();
        exec(8'hc1, 8'h00, 5'h0a);
        exec(8'hd1, 8'h00, 5'h0a);
        exec(8'he1, 8'h00, 5'h0a);
        check({regs.b, regs.c}, 16'ha4a5);
        check({regs.d, regs.e}, 16'ha6a7);
        check({regs.h, regs.l}, 16'ha0a1);
        check(regs.sp, 16'h0006);
        check(regs.pc, 16'h0005);
    endtask

    task automatic t_copies();
        logic [7:0] want [8];
        want = '{8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha0, 8'ha4, 8'h00, 8'ha4};
        exec(8'h68, 8'h00, 5'h05);
        check(16'(regs.l), 16'h00a4);
        for (int s = 0; s < 8; s++)
        begin
            if (s != 6)
            begin
                exec(8'h78 | 8'(s), 8'h00, 5'h05);
                check(16'(regs.a), 16'(want[s]));
            end
        end
    endtask

    task automatic t_or_forms();
        exec(8'hb2, 8'h00, 5'h04);
        check({regs.a, regs.f}, 16'ha686);
        exec(8'hb6, 8'h00, 5'h07);
        check({regs.a, regs.f}, 16'ha782);
    endtask

    task automatic t_rotates();
        exec(8'h07, 8'h00, 5'h04);
        check({regs.f, regs.a}, 16'h834f);
        exec(8'h17, 8'h00, 5'h04);
        check({regs.f, regs.a}, 16'h829f);
        exec(8'h1f, 8'h00, 5'h04);
        check({regs.f, regs.a}, 16'h834f);
    endtask

    // pushed bc comes back in de, pushed flags word overwrites a changed a
    task automatic t_stack_words();
        exec(8'hf5, 8'h00, 5'h0b);
        exec(8'hc5, 8'h00, 5'h0b);
        check({i_cod_mem_model.store[5], i_cod_mem_model.store[4]}, 16'h4f83);
        check({i_cod_mem_model.store[3], i_cod_mem_model.store[2]}, 16'ha4a5);
        check(regs.sp, 16'h0002);
        exec(8'hd1, 8'h00, 5'h0a);
        check({regs.d, regs.e}, 16'ha4a5);
        exec(8'hf6, 8'h30, 5'h07);
        exec(8'hf1, 8'h00, 5'h0a);
        check({regs.a, regs.f}, 16'h4f83);
        check(regs.sp, 16'h0006);
    endtask

    task automatic t_jump_returns();
        exec(8'he9, 8'h00, 5'h05);
        check(regs.pc, 16'ha0a4);
        exec(8'hd0, 8'h00, 5'h05);
        exec(8'hf0, 8'h00, 5'h05);
        check(regs.pc, 16'ha0a6);
        exec(8'hd8, 8'h00, 5'h0b);
        check(regs.pc, 16'ha2a3);
        exec(8'hc0, 8'h00, 5'h0b);
        exec(8'hf8, 8'h00, 5'h0b);
        check(regs.pc, 16'haeaf);
        exec(8'hc9, 8'h00, 5'h0a);
        check(regs.pc, 16'ha8a9);
        check(regs.sp, 16'h000e);
    endtask

    task automatic t_loads_output();
        exec(8'h00, 8'h00, 5'h04);
        exec(8'h06, 8'h55, 5'h07);
        check(16'(regs.b), 16'h0055);
        exec(8'h36, 8'h77, 5'h0a);
        check(16'(i_cod_mem_model.store[8'ha4]), 16'h0077);
        exec(8'hd3, 8'h12, 5'h0a);
        check({io_port, io_data}, 16'h124f);
        check(regs.pc, 16'ha8b0);
        exec(8'h7e, 8'h00, 5'h04);
        check(16'(illegal), 16'h0001);
    endtask

    ////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        start = 1'b0;
        opcode = 8'h00;
        operand = 8'h00;
        mismatches = 0;
        total_checks = 0;
        ticks = 0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        t_or_immediate();
        t_pull_pairs();
        t_copies();
        t_or_forms();
        t_rotates();
        t_stack_words();
        t_jump_returns();
        t_loads_output();
        give_verdict();
    end
endmodule
